// ===== core/gpio_port.sv
// Functional notes
// - Nine pins, each a general input, general output or alternate function.
// - Fundamental reset returns every pin to general input with its driver off.
// - Pin inputs are synchronised and sampled no faster than once per 128 ns.
// - Each pin owns one function-select, one direction and one data bit.
// - Function 0/direction 0 is input, 0/1 is output, function 1 is alternate.
// - A general input pin is sampled into its data bit.
// - Reading data returns the sampled pin level in every mode.
// - A general output pin drives its stored data bit.
// - A per-pin alternate select chooses which alternate signal is connected.
// - Pins 0-3 partition resets alt 0, pin 4 link-up alt 1, pin 5 event alt 0 / link-active alt 1, pin 8 expander interrupt alt 0.
// - In alternate mode the pin direction follows the selected signal.
// - An unrouted alternate input is held at its inactive level.
// - A low partition reset input starts a fundamental reset of that partition.
// - Alternate outputs are hot-plug event, link-active low and link-up low.
`timescale 1ns/1ps
`include "gpio_port_map.svh"

module gpio_port
    import gpio_port_pkg::*;
#(
    parameter int PIN_COUNT = `GPIO_PIN_COUNT
) (
    input wire logic clk_sys_in,
    input wire logic arst_n_in,
    input wire logic [PIN_COUNT-1:0] pin_function_select_in,
    input wire logic [PIN_COUNT-1:0] pin_direction_config_in,
    input wire logic [PIN_COUNT-1:0] alt_function_select_in,
    input wire logic config_write_in,
    input wire logic [PIN_COUNT-1:0] pin_data_wdata_in,
    input wire logic pin_data_write_in,
    input wire gpio_port_pkg::alt_outputs_type alt_outputs_in,
    input wire logic [PIN_COUNT-1:0] pin_in,
    output logic [PIN_COUNT-1:0] pin_out,
    output logic [PIN_COUNT-1:0] pin_oe_out,
    output logic [PIN_COUNT-1:0] pin_data_out,
    output logic [PIN_COUNT-1:0] pin_function_select_out,
    output logic [PIN_COUNT-1:0] pin_direction_config_out,
    output logic [PIN_COUNT-1:0] alt_function_select_out,
    output gpio_port_pkg::alt_inputs_type alt_inputs_out,
    output logic [`GPIO_PART_COUNT-1:0] partition_reset_req_out
);
    import gpio_port_pkg::*;

    localparam int SAMPLE_NS = `GPIO_SAMPLE_NS;
    localparam int CLK_NS = `GPIO_CLK_NS;
    // Least time rounds up to whole cycles
    localparam int SAMPLE_CYCLES = (SAMPLE_NS + CLK_NS - 1) / CLK_NS;

    // Refused at elaboration: the alternate map is wired to fixed pin numbers
    if (PIN_COUNT != 9) begin : g_bad_pin_count
        $error("PIN_COUNT must be 9: alternate map is fixed");
    end

    // Configuration registers, reset to all inputs
    logic [PIN_COUNT-1:0] func_ff;
    logic [PIN_COUNT-1:0] dir_ff;
    logic [PIN_COUNT-1:0] alt_ff;
    logic [PIN_COUNT-1:0] wdata_ff;
    logic [PIN_COUNT-1:0] sample_ff;
    logic [PIN_COUNT-1:0] sync1_ff;
    logic [PIN_COUNT-1:0] sync2_ff;
    logic [PIN_COUNT-1:0] sync3_ff;
    logic [PIN_COUNT-1:0] stable_ff;
    logic sample_en;

    // Mode decode per pin
    function automatic pin_mode_type mode_of(input logic func, input logic dir);
        if (func) begin
            return mode_alt_type_e;
        end
        return dir ? mode_output_type_e : mode_input_type_e;
    endfunction : mode_of

    // Alternate signal is an output on this pin with this select
    function automatic logic alt_is_output(input int pin, input logic sel);
        if (pin == `GPIO_PIN_LINK_UP) begin
            return sel;
        end
        if (pin == `GPIO_PIN_HOTPLUG) begin
            return 1'b1;
        end
        return 1'b0;
    endfunction : alt_is_output

    // Level driven for an alternate output
    function automatic logic alt_level(input int pin, input logic sel, input alt_outputs_type ao);
        if (pin == `GPIO_PIN_LINK_UP) begin
            return ao.port0_link_up_n;
        end
        if (pin == `GPIO_PIN_HOTPLUG) begin
            return sel ? ao.port0_link_active_n : ao.hotplug_event_out_n;
        end
        return 1'b1;
    endfunction : alt_level

    gpio_sample_strobe #(
        .PERIOD_CYCLES(SAMPLE_CYCLES)
    ) u_strobe (
        .clk_sys_in(clk_sys_in),
        .arst_n_in(arst_n_in),
        .strobe_out(sample_en)
    );

    // Configuration and stored data writes
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            func_ff <= `GPIO_FUNC_RESET;
            dir_ff <= `GPIO_DIR_RESET;
            alt_ff <= `GPIO_ALT_RESET;
            wdata_ff <= `GPIO_DATA_RESET;
        end else begin
            if (config_write_in) begin
                func_ff <= pin_function_select_in;
                dir_ff <= pin_direction_config_in;
                alt_ff <= alt_function_select_in;
            end
            if (pin_data_write_in) begin
                wdata_ff <= pin_data_wdata_in;
            end
        end
    end

    // Three-stage synchroniser; a change counts once stages two and three agree
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
            sync3_ff <= '0;
            stable_ff <= '0;
        end else begin
            sync1_ff <= pin_in;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            stable_ff <= (sync2_ff & sync3_ff) | (stable_ff & (sync2_ff | sync3_ff));
        end
    end

    // Sampled level only moves on the strobe, in every mode
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sample_ff <= '0;
        end else if (sample_en) begin
            sample_ff <= stable_ff;
        end
    end

    // Per-pin drive and enable
    logic [PIN_COUNT-1:0] nxt_pin;
    logic [PIN_COUNT-1:0] nxt_oe;
    always_comb begin
        nxt_pin = '0;
        nxt_oe = '0;
        for (int i = 0; i < PIN_COUNT; i++) begin
            case (mode_of(func_ff[i], dir_ff[i]))
                mode_output_type_e: begin
                    nxt_oe[i] = 1'b1;
                    nxt_pin[i] = wdata_ff[i];
                end
                mode_alt_type_e: begin
                    nxt_oe[i] = alt_is_output(i, alt_ff[i]);
                    nxt_pin[i] = alt_level(i, alt_ff[i], alt_outputs_in);
                end
                default: begin
                    nxt_oe[i] = 1'b0;
                    nxt_pin[i] = 1'b0;
                end
            endcase
        end
    end

    // Alternate inputs, held inactive high unless routed
    alt_inputs_type nxt_alt_in;
    always_comb begin
        for (int p = 0; p < `GPIO_PART_COUNT; p++) begin
            nxt_alt_in.partition_reset_n[p] = (func_ff[p] && !alt_ff[p]) ? sample_ff[p] : 1'b1;
        end
        nxt_alt_in.expander_interrupt_n = (func_ff[`GPIO_PIN_EXPANDER] && !alt_ff[`GPIO_PIN_EXPANDER])
            ? sample_ff[`GPIO_PIN_EXPANDER] : 1'b1;
    end

    // Registered outputs
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pin_out <= '0;
            pin_oe_out <= '0;
            pin_data_out <= '0;
            pin_function_select_out <= '0;
            pin_direction_config_out <= '0;
            alt_function_select_out <= '0;
            alt_inputs_out <= '1;
            partition_reset_req_out <= '0;
        end else begin
            pin_out <= nxt_pin;
            pin_oe_out <= nxt_oe;
            pin_data_out <= sample_ff;
            pin_function_select_out <= func_ff;
            pin_direction_config_out <= dir_ff;
            alt_function_select_out <= alt_ff;
            alt_inputs_out <= nxt_alt_in;
            partition_reset_req_out <= ~nxt_alt_in.partition_reset_n;
        end
    end

    // Checks
    a_reset_all_inputs: assert property (@(posedge clk_sys_in) $rose(arst_n_in) |-> pin_oe_out == '0)
        else $error("pins driven right after reset");
    a_output_drives_data: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        (!func_ff[0] && dir_ff[0]) |=> (pin_oe_out[0] && pin_out[0] == $past(wdata_ff[0])))
        else $error("output pin not driving data");
    a_input_not_driven: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        (!func_ff[1] && !dir_ff[1]) |=> !pin_oe_out[1])
        else $error("input pin driven");
    a_sample_on_strobe: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        !sample_en |=> $stable(sample_ff))
        else $error("sample moved without strobe");
    a_unrouted_held_high: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        !func_ff[0] |=> alt_inputs_out.partition_reset_n[0])
        else $error("unrouted partition reset not high");
    a_partition_reset_req: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        (func_ff[2] && !alt_ff[2] && !sample_ff[2]) |=> partition_reset_req_out[2])
        else $error("partition reset not requested");
    a_alt_hotplug_dir: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        func_ff[`GPIO_PIN_HOTPLUG] |=> pin_oe_out[`GPIO_PIN_HOTPLUG])
        else $error("hot-plug alternate not driven");
    a_data_reads_pin: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        sample_en |=> ##1 pin_data_out == $past(stable_ff, 2))
        else $error("data does not show pin level");
endmodule : gpio_port

// ===== common/gpio_port_map.svh
`ifndef GPIO_PORT_MAP_SVH
`define GPIO_PORT_MAP_SVH

// Pin count and reset values
`define GPIO_PIN_COUNT 9
`define GPIO_FUNC_RESET 9'h000
`define GPIO_DIR_RESET 9'h000
`define GPIO_DATA_RESET 9'h000
`define GPIO_ALT_RESET 9'h000

// Fixed pin positions of alternate signals
`define GPIO_PIN_LINK_UP 4
`define GPIO_PIN_HOTPLUG 5
`define GPIO_PIN_EXPANDER 8
`define GPIO_PART_COUNT 4

// Sampling interval
`define GPIO_SAMPLE_NS 128
`define GPIO_CLK_NS 10

`endif

// ===== common/gpio_port_pkg.sv
package gpio_port_pkg;
    // Pin modes as decoded from function select and direction
    typedef enum logic [2:0] {
        mode_input_type_e = 3'b001,
        mode_output_type_e = 3'b010,
        mode_alt_type_e = 3'b100
    } pin_mode_type;

    // Alternate output signals presented by the switch core
    typedef struct packed {
        logic hotplug_event_out_n;
        logic port0_link_active_n;
        logic port0_link_up_n;
    } alt_outputs_type;

    // Alternate input signals delivered to the switch core
    typedef struct packed {
        logic [3:0] partition_reset_n;
        logic expander_interrupt_n;
    } alt_inputs_type;
endpackage : gpio_port_pkg

// ===== core/gpio_sample_strobe.sv
`timescale 1ns/1ps
`include "gpio_port_map.svh"

// Free-running divider giving one-cycle sample strobes
module gpio_sample_strobe #(
    parameter int PERIOD_CYCLES = 13
) (
    input wire logic clk_sys_in,
    input wire logic arst_n_in,
    output logic strobe_out
);
    localparam int CW = $clog2(PERIOD_CYCLES + 1);
    logic [CW-1:0] count_ff;
    logic [CW-1:0] nxt_count;
    logic wrap;

    // Refused at elaboration: a zero period has no wrap point
    if (PERIOD_CYCLES < 1) begin : g_bad_period
        $error("PERIOD_CYCLES must be at least one");
    end

    // Wrap at the end of the period
    assign wrap = (count_ff == CW'(PERIOD_CYCLES - 1));
    assign nxt_count = wrap ? '0 : count_ff + CW'(1);

    // Counter and strobe flop
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            count_ff <= '0;
            strobe_out <= 1'b0;
        end else begin
            count_ff <= nxt_count;
            strobe_out <= wrap;
        end
    end
endmodule : gpio_sample_strobe

// ===== tb/gpio_board_model.sv
`timescale 1ns/1ps

// Board wiring: the switch wins where it drives, the board elsewhere
module gpio_board_model #(
    parameter int PIN_COUNT = 9
) (
    input wire logic [PIN_COUNT-1:0] pin_drive_in,
    input wire logic [PIN_COUNT-1:0] pin_oe_in,
    input wire logic [PIN_COUNT-1:0] board_level_in,
    output logic [PIN_COUNT-1:0] pin_level_out
);
    // Board never fights a driven pin, so no contention is modelled
    assign pin_level_out = (pin_oe_in & pin_drive_in) | (~pin_oe_in & board_level_in);
endmodule : gpio_board_model

// ===== tb/tb_top.sv
`timescale 1ns/1ps

module tb_top;
    import gpio_port_pkg::*;
    localparam int N = 9;
    logic clk_sys_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic [N-1:0] func = '0, dir = '0, alt = '0, wdata = '0, board = '0;
    logic cfg_wr = 1'b0, data_wr = 1'b0;
    alt_outputs_type alt_o = '0;
    logic [N-1:0] level, pin_out, pin_oe, data_rd, func_rd, dir_rd, alt_rd, e_oe, e_lvl, e_alt;
    alt_inputs_type alt_i;
    logic [3:0] part_req;
    int err_total = 0;
    int samples_checked = 0;
    int unsigned seed_val;

    always #5 clk_sys_in = ~clk_sys_in;

    gpio_port #(.PIN_COUNT(N)) uut (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
        .pin_function_select_in(func), .pin_direction_config_in(dir), .alt_function_select_in(alt),
        .config_write_in(cfg_wr), .pin_data_wdata_in(wdata), .pin_data_write_in(data_wr),
        .alt_outputs_in(alt_o), .pin_in(level), .pin_out(pin_out), .pin_oe_out(pin_oe),
        .pin_data_out(data_rd), .pin_function_select_out(func_rd), .pin_direction_config_out(dir_rd),
        .alt_function_select_out(alt_rd), .alt_inputs_out(alt_i), .partition_reset_req_out(part_req));

    gpio_board_model #(.PIN_COUNT(N)) board_model (.pin_drive_in(pin_out), .pin_oe_in(pin_oe),
        .board_level_in(board), .pin_level_out(level));

    // Expected driver enables: general pins by direction, alternates by signal kind
    function automatic logic [N-1:0] exp_oe(logic [N-1:0] f, logic [N-1:0] d, logic [N-1:0] a);
        logic [N-1:0] r;
        r = ~f & d;
        r[4] = f[4] ? a[4] : d[4];
        r[5] = f[5] ? 1'b1 : d[5];
        return r;
    endfunction : exp_oe

    // Expected drive value on driven pins only
    function automatic logic [N-1:0] exp_drv(logic [N-1:0] f, logic [N-1:0] a, logic [N-1:0] w);
        logic [N-1:0] r;
        r = w;
        r[4] = f[4] ? alt_o.port0_link_up_n : w[4];
        r[5] = f[5] ? (a[5] ? alt_o.port0_link_active_n : alt_o.hotplug_event_out_n) : w[5];
        return r;
    endfunction : exp_drv

    // Routed alternate inputs follow the pin, unrouted ones sit inactive high
    function automatic logic [N-1:0] exp_alt_in(logic [N-1:0] f, logic [N-1:0] a, logic [N-1:0] l);
        logic [N-1:0] r;
        r = N'(5'h1f);
        for (int i = 0; i < 4; i++) begin
            if (f[i] && !a[i]) begin
                r[i+1] = l[i];
            end
        end
        r[0] = (f[8] && !a[8]) ? l[8] : 1'b1;
        return r;
    endfunction : exp_alt_in

    task automatic check(string what, logic [N-1:0] exp, logic [N-1:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : close_out

    // Data is written before the mode change so the stored value must survive it
    task automatic run_case(int t, logic [N-1:0] f, logic [N-1:0] d, logic [N-1:0] a);
        @(posedge clk_sys_in);
        #1;
        wdata = N'($urandom);
        data_wr = 1'b1;
        @(posedge clk_sys_in);
        #1;
        data_wr = 1'b0;
        func = f;
        dir = d;
        alt = a;
        cfg_wr = 1'b1;
        board = N'($urandom);
        alt_o = 3'($urandom);
        @(posedge clk_sys_in);
        #1;
        cfg_wr = 1'b0;
        repeat (40) @(posedge clk_sys_in);
        #1;
        // Expected pin level: our drive where enabled, the board elsewhere
        e_oe = exp_oe(f, d, a);
        e_lvl = (e_oe & exp_drv(f, a, wdata)) | (~e_oe & board);
        e_alt = exp_alt_in(f, a, e_lvl);
        check("func_readback", f, func_rd);
        check("dir_readback", d, dir_rd);
        check("alt_readback", a, alt_rd);
        check("pin_oe", e_oe, pin_oe);
        check("pin_drive", e_oe & exp_drv(f, a, wdata), e_oe & pin_out);
        check("pin_data", e_lvl, data_rd);
        check("alt_inputs", e_alt, {4'h0, alt_i});
        check("part_req", {5'h00, ~e_alt[4:1]}, {5'h00, part_req});
        $display("test %0d done", t);
    endtask : run_case

    initial begin
        seed_val = $urandom(32'h0000_ccfb);
        repeat (20) @(posedge clk_sys_in);
        #1;
        check("oe_in_reset", '0, pin_oe);
        check("alt_in_reset", 9'h01f, {4'h0, alt_i});
        arst_n_in = 1'b1;
        repeat (2) @(posedge clk_sys_in);
        #1;
        check("oe_after_reset", '0, pin_oe);
        run_case(0, 9'h000, 9'h000, 9'h000);
        run_case(1, 9'h000, 9'h1ff, 9'h000);
        // Mid-run reset while every pin drives: drivers must drop and config clear
        arst_n_in = 1'b0;
        repeat (3) @(posedge clk_sys_in);
        #1;
        check("oe_in_mid_reset", '0, pin_oe);
        arst_n_in = 1'b1;
        repeat (2) @(posedge clk_sys_in);
        #1;
        check("oe_after_mid_reset", '0, pin_oe);
        check("func_after_mid_reset", '0, func_rd);
        check("dir_after_mid_reset", '0, dir_rd);
        $display("test reset done");
        run_case(2, 9'h1ff, 9'h000, 9'h010);
        run_case(3, 9'h1ff, 9'h1ff, 9'h1ff);
        run_case(4, 9'h1ff, 9'h0aa, 9'h02f);
        for (int t = 5; t < 20; t++) begin
            run_case(t, N'($urandom), N'($urandom), N'($urandom));
        end
        close_out();
    end

    // Cases take under 1 us each; this bound is far beyond the whole run
    initial begin
        #100000;
        err_total++;
        close_out();
    end
endmodule : tb_top
